// File: verilog/usbef_top.v
// USB endpoint FIFOs, suspend/resume control and PS2 pin mux
`timescale 1ns/1ps
`include "usbef_consts.vh"

//////////////////////////////////////////////////////////////////////////////
// Operation
// - Flush empties selected FIFO even if unready
// - Select 00/01/10 picks FIFO 0/1/2
// - SETUP sets flag; only firmware clears it
// - Zero-length flag; cleared by read or SETUP
// - Eight bytes per packet, no byte count
// - Wait 2 us, ENDPOINT1_FIFO_DATA write shows 4BH ready
// - ENDPOINT0_FIFO_DATA read steps 00,01,41,01,03,02
// - ENDPOINT1_FIFO_DATA write steps 0A,0B,4B,0B,09,08
// - Zero-length send steps 02,03,43,01,00
// - Host-owned pipe blocked; done raises interrupt, number
// - Idle over 3 ms sets suspend, interrupt
// - Host resume sets resume bit, interrupt
// - Resume clears first, then suspend drops, interrupt
// - Wake bit drives remote wake-up on bus
// - PS2 or serial engine owns the pins
// - PS2 input reads pin only when output high
// - Both port select bits reset to zero
// - Command bit map zlen,rdy,setup,sel,clr,tx,req
module usbef_top #(
   parameter IDLE_CYC = `USBEF_IDLE_CYC,
   parameter DEPTH    = `USBEF_DEPTH
) (
   input  wire       I_MCLK,
   input  wire       I_RST_N,
   input  wire [7:0] I_ADDR,
   input  wire [7:0] I_WDATA,
   input  wire       I_WR,
   input  wire       I_RD,
   output reg  [7:0] O_RDATA,
   input  wire [2:0] I_SIE_BUSY,
   input  wire [1:0] I_SIE_PIPE,
   input  wire       I_SIE_WR,
   input  wire [7:0] I_SIE_WDATA,
   input  wire       I_SIE_RD,
   output reg  [7:0] O_SIE_RDATA,
   input  wire       I_SIE_DONE,
   input  wire       I_SIE_SETUP,
   input  wire       I_SIE_ZLEN,
   input  wire       I_SIE_BUS_RESET,
   input  wire       I_BUS_ACTIVE,
   input  wire       I_RESUME_DET,
   output reg  [2:0] O_PKT_COMMIT,
   output reg        O_USB_INT,
   output reg  [1:0] O_FINISHED_PIPE_NUMBER,
   output reg        O_REMOTE_WAKE,
   input  wire       I_SIE_DM_O,
   input  wire       I_SIE_DP_O,
   input  wire       I_SIE_OE,
   input  wire       I_DM_I,
   input  wire       I_DP_I,
   output reg        O_DM_O,
   output reg        O_DM_OE,
   output reg        O_DP_O,
   output reg        O_DP_OE
);

   localparam PW = $clog2(DEPTH);
   localparam CW = PW + 1;
   localparam IW = $clog2(IDLE_CYC + 1);
   localparam [CW-1:0] CFULL = DEPTH[CW-1:0];

   //////////////////////////////////////////////////////////////////////////
   // Command register
   reg        req_q;
   reg        tx_q;
   reg        clr_q;
   reg  [1:0] sel_q;
   reg        setup_q;
   reg        zlen_q;
   reg  [7:0] usc_q;
   reg  [2:0] epf_q;
   reg        ps2_q;
   reg        usb_q;
   reg        uflag_q;
   reg        susp_q;
   reg        resm_q;
   reg        urst_q;
   reg        end_pend_q;
   reg        rdet_q;
   reg  [IW-1:0] idle_q;

   wire [PW*3-1:0] wp_all;
   wire [PW*3-1:0] rp_all;
   wire [2:0]      full_v;
   wire [2:0]      empty_v;

   wire wr_cmd  = I_WR && (I_ADDR == `USBEF_A_CMD);
   wire wr_usc  = I_WR && (I_ADDR == `USBEF_A_USC);
   wire wr_usr  = I_WR && (I_ADDR == `USBEF_A_USR);
   wire acc_f   = (I_ADDR == `USBEF_A_F0) || (I_ADDR == `USBEF_A_F1) ||
                  (I_ADDR == `USBEF_A_F2);
   wire [1:0] afsel = I_ADDR[1:0];

   // Selected FIFO state, none when select is 11
   wire sel_ok  = (sel_q != `USBEF_SEL_NONE);
   wire s_full  = sel_ok ? full_v[sel_q] : 1'b1;
   wire s_empty = sel_ok ? empty_v[sel_q] : 1'b1;
   wire s_busy  = sel_ok ? I_SIE_BUSY[sel_q] : 1'b1;
   // Ready: writes while room, reads while data
   wire ready   = req_q && sel_ok && !s_busy &&
                  (tx_q ? !s_full : !s_empty);

   wire mcu_ok  = acc_f && ready && (afsel == sel_q);
   wire mcu_wr  = I_WR && mcu_ok && tx_q;
   wire mcu_rd  = I_RD && mcu_ok && !tx_q;
   wire flush   = clr_q && sel_ok;
   wire pipe_ok = (I_SIE_PIPE != `USBEF_SEL_NONE);
   wire sie_wr  = I_SIE_WR && pipe_ok && !full_v[I_SIE_PIPE];
   wire sie_rd  = I_SIE_RD && pipe_ok && !empty_v[I_SIE_PIPE];

   // Write end: direction falls while still requested
   wire tx_end  = wr_cmd && req_q && tx_q &&
                  !I_WDATA[`USBEF_B_TX] && sel_ok;

   always @(posedge I_MCLK) begin
      if (!I_RST_N) begin
         req_q   <= 1'b0;
         tx_q    <= 1'b0;
         clr_q   <= 1'b0;
         sel_q   <= 2'h0;
         setup_q <= 1'b0;
         zlen_q  <= 1'b0;
      end else begin
         if (wr_cmd) begin
            req_q <= I_WDATA[`USBEF_B_REQ];
            tx_q  <= I_WDATA[`USBEF_B_TX];
            clr_q <= I_WDATA[`USBEF_B_CLR];
            sel_q <= {I_WDATA[`USBEF_B_SELHI],
                      I_WDATA[`USBEF_B_SELLO]};
         end
         // Setting event wins over firmware clear
         if (I_SIE_SETUP)
            setup_q <= 1'b1;
         else if (wr_cmd && !I_WDATA[`USBEF_B_SETUP])
            setup_q <= 1'b0;
         if (I_SIE_ZLEN)
            zlen_q <= 1'b1;
         else if (I_SIE_SETUP || (I_RD && acc_f))
            zlen_q <= 1'b0;
         else if (wr_cmd && !I_WDATA[`USBEF_B_ZLEN])
            zlen_q <= 1'b0;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Endpoint FIFOs, one shared array
   reg [7:0] mem [0:3*DEPTH-1];

   genvar g;
   generate
      for (g = 0; g < `USBEF_NFIFO; g = g + 1) begin : g_fifo
         reg  [CW-1:0] cnt_q;
         reg  [PW-1:0] wp_q;
         reg  [PW-1:0] rp_q;
         wire [31:0]   gi = g;
         wire [1:0]    id = gi[1:0];
         wire push = (mcu_wr && (sel_q == id)) ||
                     (sie_wr && (I_SIE_PIPE == id));
         wire pop  = (mcu_rd && (sel_q == id)) ||
                     (sie_rd && (I_SIE_PIPE == id));
         wire fl   = flush && (sel_q == id);
         always @(posedge I_MCLK) begin
            if (!I_RST_N || fl) begin
               cnt_q <= {CW{1'b0}};
               wp_q  <= {PW{1'b0}};
               rp_q  <= {PW{1'b0}};
            end else begin
               if (push)
                  wp_q <= wp_q + 1'b1;
               if (pop)
                  rp_q <= rp_q + 1'b1;
               if (push && !pop)
                  cnt_q <= cnt_q + 1'b1;
               else if (pop && !push)
                  cnt_q <= cnt_q - 1'b1;
            end
         end
         assign wp_all[g*PW +: PW]  = wp_q;
         assign rp_all[g*PW +: PW]  = rp_q;
         // Eight-byte packet limit shows only as full
         assign full_v[g]  = (cnt_q == CFULL);
         assign empty_v[g] = (cnt_q == {CW{1'b0}});
      end
   endgenerate

   wire [PW-1:0] m_wp = wp_all[sel_q*PW +: PW];
   wire [PW-1:0] m_rp = rp_all[sel_q*PW +: PW];
   wire [PW-1:0] s_wp = wp_all[I_SIE_PIPE*PW +: PW];
   wire [PW-1:0] s_rp = rp_all[I_SIE_PIPE*PW +: PW];
   wire [7:0]    m_rdat = mem[sel_q*DEPTH + m_rp];

   // Owners never share a pipe, so writes do not collide
   always @(posedge I_MCLK) begin
      if (mcu_wr)
         mem[sel_q*DEPTH + m_wp] <= I_WDATA;
      if (sie_wr)
         mem[I_SIE_PIPE*DEPTH + s_wp] <= I_SIE_WDATA;
   end

   always @(posedge I_MCLK) begin
      if (!I_RST_N)
         O_SIE_RDATA <= 8'h00;
      else if (sie_rd)
         O_SIE_RDATA <= mem[I_SIE_PIPE*DEPTH + s_rp];
   end

   //////////////////////////////////////////////////////////////////////////
   // Suspend, resume and remote wake-up
   wire idle_hit  = !susp_q && (idle_q == IDLE_CYC[IW-1:0]);
   wire resm_set  = susp_q && I_RESUME_DET && !rdet_q;
   wire resm_end  = susp_q && !I_RESUME_DET && rdet_q;

   always @(posedge I_MCLK) begin
      if (!I_RST_N) begin
         idle_q     <= {IW{1'b0}};
         susp_q     <= 1'b0;
         resm_q     <= 1'b0;
         end_pend_q <= 1'b0;
         rdet_q     <= 1'b0;
      end else begin
         rdet_q <= I_RESUME_DET;
         if (I_BUS_ACTIVE || susp_q)
            idle_q <= {IW{1'b0}};
         else if (!idle_hit)
            idle_q <= idle_q + 1'b1;
         if (idle_hit)
            susp_q <= 1'b1;
         else if (end_pend_q)
            susp_q <= 1'b0;
         // Resume bit goes one cycle ahead of suspend
         if (resm_set)
            resm_q <= 1'b1;
         else if (resm_end)
            resm_q <= 1'b0;
         end_pend_q <= resm_end;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Status/control and port select registers
   wire [2:0] ep_set = (I_SIE_DONE && pipe_ok) ?
                       (3'h1 << I_SIE_PIPE) : 3'h0;

   always @(posedge I_MCLK) begin
      if (!I_RST_N) begin
         usc_q   <= `USBEF_USC_RST;
         urst_q  <= 1'b0;
         epf_q   <= 3'h0;
         ps2_q   <= 1'b0;
         usb_q   <= 1'b0;
         uflag_q <= 1'b0;
      end else begin
         if (wr_usc) begin
            usc_q[`USBEF_B_WAKE] <= I_WDATA[`USBEF_B_WAKE];
            usc_q[`USBEF_B_DAO]  <= I_WDATA[`USBEF_B_DAO];
            usc_q[`USBEF_B_CKO]  <= I_WDATA[`USBEF_B_CKO];
         end
         if (I_SIE_BUS_RESET)
            urst_q <= 1'b1;
         else if (wr_usc && !I_WDATA[`USBEF_B_URST])
            urst_q <= 1'b0;
         if (wr_usr) begin
            ps2_q   <= I_WDATA[`USBEF_B_PS2];
            usb_q   <= I_WDATA[`USBEF_B_USB];
            uflag_q <= I_WDATA[`USBEF_B_UFLAG];
         end
         // Done flag set wins; writing 0 clears
         if (wr_usr)
            epf_q <= (epf_q & I_WDATA[2:0]) | ep_set;
         else
            epf_q <= epf_q | ep_set;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Pin ownership, registered outputs
   wire ps2_mode = ps2_q && !usb_q;
   wire usb_mode = usb_q && !ps2_q;
   // Open drain: input only valid while output released
   wire dai = I_DM_I && usc_q[`USBEF_B_DAO];
   wire cki = I_DP_I && usc_q[`USBEF_B_CKO];

   always @(posedge I_MCLK) begin
      if (!I_RST_N) begin
         O_DM_O  <= 1'b0;
         O_DM_OE <= 1'b0;
         O_DP_O  <= 1'b0;
         O_DP_OE <= 1'b0;
      end else if (ps2_mode) begin
         O_DM_O  <= 1'b0;
         O_DM_OE <= !usc_q[`USBEF_B_DAO];
         O_DP_O  <= 1'b0;
         O_DP_OE <= !usc_q[`USBEF_B_CKO];
      end else if (usb_mode) begin
         O_DM_O  <= I_SIE_DM_O;
         O_DM_OE <= I_SIE_OE;
         O_DP_O  <= I_SIE_DP_O;
         O_DP_OE <= I_SIE_OE;
      end else begin
         O_DM_O  <= 1'b0;
         O_DM_OE <= 1'b0;
         O_DP_O  <= 1'b0;
         O_DP_OE <= 1'b0;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Events and interrupt pulse
   always @(posedge I_MCLK) begin
      if (!I_RST_N) begin
         O_USB_INT              <= 1'b0;
         O_FINISHED_PIPE_NUMBER <= 2'h0;
         O_PKT_COMMIT           <= 3'h0;
         O_REMOTE_WAKE          <= 1'b0;
      end else begin
         O_USB_INT <= (I_SIE_DONE && pipe_ok) || idle_hit ||
                      resm_set || end_pend_q;
         if (I_SIE_DONE && pipe_ok)
            O_FINISHED_PIPE_NUMBER <= I_SIE_PIPE;
         O_PKT_COMMIT  <= tx_end ? (3'h1 << sel_q) : 3'h0;
         O_REMOTE_WAKE <= usc_q[`USBEF_B_WAKE];
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Register read, data one cycle after strobe
   reg [7:0] rd_d;
   always @* begin
      rd_d = 8'h00;
      case (I_ADDR)
         `USBEF_A_CMD: begin
            rd_d = {zlen_q, ready, setup_q, sel_q,
                    clr_q, tx_q, req_q};
         end
         `USBEF_A_F0, `USBEF_A_F1, `USBEF_A_F2: begin
            rd_d = mcu_rd ? m_rdat : 8'h00;
         end
         `USBEF_A_USC: begin
            rd_d = {usc_q[`USBEF_B_CKO], usc_q[`USBEF_B_DAO], cki, dai,
                    resm_q, urst_q, 1'b0, susp_q};
         end
         `USBEF_A_USR: begin
            rd_d = {uflag_q, 1'b0, usb_q, ps2_q, 1'b0, epf_q};
         end
         default: begin
            rd_d = 8'h00;
         end
      endcase
   end

   always @(posedge I_MCLK) begin
      if (!I_RST_N)
         O_RDATA <= 8'h00;
      else if (I_RD)
         O_RDATA <= rd_d;
      else
         O_RDATA <= 8'h00;
   end

endmodule

// File: pkg/usbef_consts.vh
// Constants for the USB endpoint FIFO and suspend control block
`ifndef USBEF_CONSTS_VH
`define USBEF_CONSTS_VH
`define USBEF_A_CMD    8'h46
`define USBEF_A_F0     8'h48
`define USBEF_A_F1     8'h49
`define USBEF_A_F2     8'h4a
`define USBEF_A_USC    8'h1a
`define USBEF_A_USR    8'h1b
`define USBEF_B_REQ    0
`define USBEF_B_TX     1
`define USBEF_B_CLR    2
`define USBEF_B_SELLO  3
`define USBEF_B_SELHI  4
`define USBEF_B_SETUP  5
`define USBEF_B_RDY    6
`define USBEF_B_ZLEN   7
`define USBEF_B_SUSP   0
`define USBEF_B_WAKE   1
`define USBEF_B_URST   2
`define USBEF_B_RESM   3
`define USBEF_B_DAI    4
`define USBEF_B_CKI    5
`define USBEF_B_DAO    6
`define USBEF_B_CKO    7
`define USBEF_B_PS2    4
`define USBEF_B_USB    5
`define USBEF_B_UFLAG  7
`define USBEF_SEL_F0   2'h0
`define USBEF_SEL_F1   2'h1
`define USBEF_SEL_F2   2'h2
`define USBEF_SEL_NONE 2'h3
`define USBEF_NFIFO    3
`define USBEF_DEPTH    8
`define USBEF_IDLE_US  3000
`define USBEF_CLK_MHZ  25
`define USBEF_IDLE_CYC (`USBEF_IDLE_US * `USBEF_CLK_MHZ)
`define USBEF_CMD_RST  8'h00
`define USBEF_USC_RST  8'hc0
`endif

// File: dv/usbef_sva.sv
// Port-level checks for the endpoint FIFO and suspend block
`timescale 1ns/1ps
module usbef_sva #(
   parameter IDLE_CYC = 20
) (
   input wire       I_MCLK,
   input wire       I_RST_N,
   input wire [7:0] I_ADDR,
   input wire [7:0] I_WDATA,
   input wire       I_WR,
   input wire       I_RD,
   input wire [7:0] O_RDATA,
   input wire [1:0] I_SIE_PIPE,
   input wire       I_SIE_DONE,
   input wire       I_BUS_ACTIVE,
   input wire [2:0] O_PKT_COMMIT,
   input wire       O_USB_INT,
   input wire [1:0] O_FINISHED_PIPE_NUMBER,
   input wire       O_REMOTE_WAKE
);
   reg  [4:0]  cmd_q;
   reg  [31:0] idle_q;
   wire        cmd_wr  = I_WR && I_ADDR == 8'h46;
   wire        rd_cmd  = I_RD && I_ADDR == 8'h46;
   wire        rd_usc  = I_RD && I_ADDR == 8'h1a;
   wire        rd_none = rd_cmd && cmd_q[4:3] == 2'h3;
   wire        rd_bad  = I_RD && I_ADDR == 8'h47;
   default clocking @(posedge I_MCLK); endclocking
   default disable iff (!I_RST_N);
   ////////////////////////////////////////
   always @(posedge I_MCLK) begin
      if (!I_RST_N) begin
         cmd_q  <= 5'h00;
         idle_q <= 32'h0;
      end else begin
         if (cmd_wr) begin
            cmd_q <= I_WDATA[4:0];
         end
         // Saturates so one idle stretch fires once
         if (I_BUS_ACTIVE) begin
            idle_q <= 32'h0;
         end else if (idle_q < IDLE_CYC + 8) begin
            idle_q <= idle_q + 32'h1;
         end
      end
   end
   sequence write_end_s;
      cmd_wr && cmd_q[1] && cmd_q[0] && !I_WDATA[1] && I_WDATA[0]
         && I_WDATA[4:3] == cmd_q[4:3] && cmd_q[4:3] != 2'h3;
   endsequence
   rd_idle_a: assert property (!$past(I_RD) |-> O_RDATA == 8'h00)
      else $error("read data not idle");
   pipe_done_a: assert property (I_SIE_DONE && I_SIE_PIPE != 2'h3
      |=> O_USB_INT && O_FINISHED_PIPE_NUMBER == $past(I_SIE_PIPE))
      else $error("pipe finish not reported");
   wake_out_a: assert property (I_WR && I_ADDR == 8'h1a ##1 1'b1
      |=> O_REMOTE_WAKE == $past(I_WDATA[1], 2))
      else $error("remote wake not following");
   wake_rdz_a: assert property ($past(rd_usc) |-> !O_RDATA[1])
      else $error("wake bit not reading zero");
   commit_a: assert property (write_end_s |=>
      O_PKT_COMMIT == 3'h1 << cmd_q[4:3])
      else $error("write end not committed");
   idle_susp_a: assert property (idle_q == IDLE_CYC - 1
      && !I_BUS_ACTIVE |-> ##[1:3] O_USB_INT)
      else $error("no interrupt on idle bus");
   cmd_back_a: assert property ($past(rd_cmd)
      |-> O_RDATA[4:0] == $past(cmd_q))
      else $error("command fields not read back");
   none_rdy_a: assert property ($past(rd_none) |-> !O_RDATA[6])
      else $error("ready with no fifo selected");
   unmap_rd_a: assert property ($past(rd_bad) |-> O_RDATA == 8'h00)
      else $error("unmapped read not zero");
endmodule

// File: dv/usbef_sie.sv
// Model of the host-side engine and the pin pull-ups
`timescale 1ns/1ps
module usbef_sie (
   input  wire        I_MCLK,
   input  wire        O_DM_O,
   input  wire        O_DM_OE,
   input  wire        O_DP_O,
   input  wire        O_DP_OE,
   output logic [2:0] I_SIE_BUSY,
   output logic [1:0] I_SIE_PIPE,
   output logic       I_SIE_WR,
   output logic [7:0] I_SIE_WDATA,
   output logic       I_SIE_RD,
   output logic       I_SIE_DONE,
   output logic       I_SIE_SETUP,
   output logic       I_SIE_ZLEN,
   output logic       I_SIE_BUS_RESET,
   output logic       I_BUS_ACTIVE,
   output logic       I_RESUME_DET,
   output logic       I_SIE_DM_O,
   output logic       I_SIE_DP_O,
   output logic       I_SIE_OE,
   output wire        I_DM_I,
   output wire        I_DP_I
);
   logic dm_low = 1'b0;
   // Pull-ups win unless someone sinks the line
   assign I_DM_I = !(O_DM_OE && !O_DM_O) && !dm_low;
   assign I_DP_I = !(O_DP_OE && !O_DP_O);
   initial begin
      {I_SIE_BUSY, I_SIE_WR, I_SIE_RD, I_SIE_DONE} = 6'h00;
      {I_SIE_SETUP, I_SIE_ZLEN, I_SIE_BUS_RESET} = 3'h0;
      {I_RESUME_DET, I_SIE_DM_O, I_SIE_DP_O, I_SIE_OE} = 4'h0;
      I_SIE_PIPE   = 2'h3;
      I_SIE_WDATA  = 8'h00;
      I_BUS_ACTIVE = 1'b1;
   end
   // Kinds: 0 push, 1 pop, 2 done, 3 setup, 4 zero-length
   task automatic pulse(input int k, input int p, input logic [7:0] d);
      @(posedge I_MCLK);
      I_SIE_PIPE  <= 2'(p);
      I_SIE_WDATA <= d;
      case (k)
         0: I_SIE_WR <= 1'b1;
         1: I_SIE_RD <= 1'b1;
         2: I_SIE_DONE <= 1'b1;
         3: I_SIE_SETUP <= 1'b1;
         default: I_SIE_ZLEN <= 1'b1;
      endcase
      @(posedge I_MCLK);
      {I_SIE_WR, I_SIE_RD, I_SIE_DONE, I_SIE_SETUP, I_SIE_ZLEN} <= 5'h00;
      I_SIE_PIPE  <= 2'h3;
      // Released data must not look valid
      I_SIE_WDATA <= ~d;
   endtask
endmodule

// File: dv/usbef_top_tb.sv
// Self-checking bench for the endpoint FIFO and suspend block
`timescale 1ns/1ps
module usbef_top_tb;
   localparam IDLE = 20;
   // Firmware spacing of 2 us at a 40 ns clock
   localparam GAP  = 50;
   logic       I_MCLK  = 1'b0;
   logic       I_RST_N = 1'b0;
   logic [7:0] I_ADDR  = 8'h00;
   logic [7:0] I_WDATA = 8'h00;
   logic       I_WR    = 1'b0;
   logic       I_RD    = 1'b0;
   wire  [7:0] O_RDATA, O_SIE_RDATA, I_SIE_WDATA;
   wire  [2:0] I_SIE_BUSY, O_PKT_COMMIT;
   wire  [1:0] I_SIE_PIPE, O_FINISHED_PIPE_NUMBER;
   wire        I_SIE_WR, I_SIE_RD, I_SIE_DONE, I_SIE_SETUP, I_SIE_ZLEN;
   wire        I_SIE_BUS_RESET, I_BUS_ACTIVE, I_RESUME_DET, O_USB_INT;
   wire        O_REMOTE_WAKE, I_SIE_DM_O, I_SIE_DP_O, I_SIE_OE;
   wire        I_DM_I, I_DP_I, O_DM_O, O_DM_OE, O_DP_O, O_DP_OE;
   int         failures = 0;
   int         samples_checked = 0;
   int         cyc = 0;
   logic [7:0] q [$];
   logic [7:0] s;
   int         n;
   usbef_top #(.IDLE_CYC(IDLE)) dut (.*);
   usbef_sie sie (.*);
   always #20 I_MCLK = ~I_MCLK;
   ////////////////////////////////////////
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge I_MCLK);
      I_WR    <= 1'b1;
      I_ADDR  <= a;
      I_WDATA <= v;
      @(posedge I_MCLK);
      I_WR <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge I_MCLK);
      I_RD   <= 1'b1;
      I_ADDR <= a;
      @(posedge I_MCLK);
      I_RD <= 1'b0;
      #1;
      chk(O_RDATA, exp);
   endtask
   task automatic gap;
      repeat (GAP) @(posedge I_MCLK);
   endtask
   task automatic pins(input logic [7:0] exp);
      #1;
      chk({4'h0, O_DM_O, O_DM_OE, O_DP_O, O_DP_OE}, exp);
   endtask
   task automatic summarize;
      $display("checked %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge I_MCLK) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         summarize;
      end
   end
   initial begin
      void'($urandom(32'haba8c92e));
      repeat (16) @(posedge I_MCLK);
      I_RST_N <= 1'b1;
      rd(8'h46, 8'h00);
      rd(8'h1b, 8'h00);
      rd(8'h1a, 8'hf0);
      wr(8'h47, 8'hff);
      rd(8'h47, 8'h00);
      sie.I_SIE_BUS_RESET <= 1'b1;
      @(posedge I_MCLK);
      sie.I_SIE_BUS_RESET <= 1'b0;
      rd(8'h1a, 8'hf4);
      wr(8'h1a, 8'hc0);
      rd(8'h1a, 8'hf0);
      $display("test reset done");
      for (int p = 0; p < 3; p++) begin
         s = 8'(p) << 3;
         n = (p == 0) ? 8 : 1 + $urandom % 8;
         q.delete();
         for (int i = 0; i < n; i++) begin
            q.push_back(8'($urandom));
            sie.pulse(0, p, q[i]);
         end
         sie.pulse(2, p, 8'h00);
         wr(8'h46, s);
         sie.I_SIE_BUSY <= 3'h1 << p;
         wr(8'h46, s | 8'h01);
         rd(8'h46, s | 8'h01);
         sie.I_SIE_BUSY <= 3'h0;
         gap;
         rd(8'h46, s | 8'h41);
         rd(8'h48 + 8'((p + 1) % 3), 8'h00);
         for (int i = 0; i < n; i++) begin
            gap;
            rd(8'h48 + 8'(p), q[i]);
         end
         rd(8'h46, s | 8'h01);
         wr(8'h46, s | 8'h03);
         wr(8'h46, s | 8'h02);
         q.delete();
         wr(8'h46, s | 8'h02);
         wr(8'h46, s | 8'h03);
         rd(8'h46, s | 8'h43);
         for (int i = 0; i < 9; i++) begin
            q.push_back(8'($urandom));
            gap;
            wr(8'h48 + 8'(p), q[i]);
         end
         rd(8'h46, s | 8'h03);
         wr(8'h46, s | 8'h01);
         wr(8'h46, s);
         for (int i = 0; i < 8; i++) begin
            sie.pulse(1, p, 8'h00);
            #1;
            chk(O_SIE_RDATA, q[i]);
         end
         $display("test fifo %0d done", p);
      end
      wr(8'h46, 8'h02);
      wr(8'h46, 8'h03);
      rd(8'h46, 8'h43);
      wr(8'h46, 8'h01);
      wr(8'h46, 8'h00);
      sie.pulse(0, 2, 8'h5a);
      wr(8'h46, 8'h14);
      wr(8'h46, 8'h11);
      rd(8'h46, 8'h11);
      sie.pulse(0, 0, 8'h33);
      wr(8'h46, 8'h19);
      rd(8'h46, 8'h19);
      rd(8'h48, 8'h00);
      wr(8'h46, 8'h01);
      rd(8'h48, 8'h33);
      wr(8'h46, 8'h00);
      sie.pulse(4, 0, 8'h00);
      rd(8'h46, 8'h80);
      rd(8'h48, 8'h00);
      rd(8'h46, 8'h00);
      sie.pulse(4, 0, 8'h00);
      sie.pulse(3, 0, 8'h00);
      wr(8'h46, 8'h20);
      rd(8'h46, 8'h20);
      wr(8'h46, 8'h00);
      rd(8'h46, 8'h00);
      $display("test flags done");
      sie.I_BUS_ACTIVE <= 1'b0;
      repeat (IDLE + 4) @(posedge I_MCLK);
      rd(8'h1a, 8'hf1);
      wr(8'h1a, 8'hc2);
      @(posedge I_MCLK);
      #1;
      chk({7'h00, O_REMOTE_WAKE}, 8'h01);
      wr(8'h1a, 8'hc0);
      sie.I_RESUME_DET <= 1'b1;
      rd(8'h1a, 8'hf9);
      sie.I_RESUME_DET <= 1'b0;
      sie.I_BUS_ACTIVE <= 1'b1;
      rd(8'h1a, 8'hf1);
      rd(8'h1a, 8'hf0);
      $display("test suspend done");
      wr(8'h1b, 8'h10);
      wr(8'h1a, 8'h40);
      repeat (2) @(posedge I_MCLK);
      pins(8'h01);
      sie.dm_low <= 1'b1;
      rd(8'h1a, 8'h40);
      sie.dm_low <= 1'b0;
      rd(8'h1a, 8'h50);
      wr(8'h1b, 8'h20);
      sie.I_SIE_OE   <= 1'b1;
      sie.I_SIE_DM_O <= 1'b1;
      repeat (3) @(posedge I_MCLK);
      pins(8'h0d);
      rd(8'h1b, 8'h20);
      $display("test pins done");
      summarize;
   end
endmodule
bind usbef_top usbef_sva #(.IDLE_CYC(IDLE_CYC)) chk (.*);
